// file: pdp_chan.sv
// one direction: current and next pointer/counter with chaining and flags
`timescale 1ns/100ps
`default_nettype none
module pdp_chan
  import pdp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  pdp_chan_if.chan bus
);

  logic [31:0] ptr_q;
  logic [31:0] nptr_q;
  logic [15:0] cnt_q;
  logic [15:0] ncnt_q;
  logic end_q;
  logic buff_q;
  logic hit;
  logic load;
  logic cnt_wr;

  // last transfer of the current buffer
  assign hit = bus.done && (cnt_q == 16'h0001);
  // chain when current is spent and a next buffer waits
  assign load = (hit || cnt_q == 16'h0000) && (ncnt_q != 16'h0000) && !bus.wr_cnt;
  assign cnt_wr = bus.wr_cnt || bus.wr_ncnt;

  // current pointer: software wins, then chaining, then advance
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_q <= PDP_PTR_RST;
    end else if (bus.wr_ptr) begin
      ptr_q <= bus.wdata;
    end else if (load) begin
      ptr_q <= nptr_q;
    end else if (bus.done) begin
      ptr_q <= ptr_q + {29'h0, bus.step};
    end
  end

  // current count: a write replaces what is left
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= PDP_CNT_RST;
    end else if (bus.wr_cnt) begin
      cnt_q <= bus.wdata[15:0];
    end else if (load) begin
      cnt_q <= ncnt_q;
    end else if (bus.done && cnt_q != 16'h0000) begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end

  // next pointer and count; count empties once taken over
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nptr_q <= PDP_PTR_RST;
      ncnt_q <= PDP_CNT_RST;
    end else begin
      if (bus.wr_nptr) begin
        nptr_q <= bus.wdata;
      end
      if (bus.wr_ncnt) begin
        ncnt_q <= bus.wdata[15:0];
      end else if (load) begin
        ncnt_q <= PDP_CNT_RST;
      end
    end
  end

  // sticky end flags; the event wins over a counter write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      end_q <= 1'b0;
      buff_q <= 1'b0;
    end else begin
      end_q <= hit || (end_q && !cnt_wr);
      buff_q <= (hit && ncnt_q == 16'h0000) || (buff_q && !cnt_wr);
    end
  end

  assign bus.ptr = ptr_q;
  assign bus.nptr = nptr_q;
  assign bus.cnt = cnt_q;
  assign bus.ncnt = ncnt_q;
  assign bus.end_flag = end_q;
  assign bus.buff_flag = buff_q;

endmodule // pdp_chan
`default_nettype wire

// file: pdp_chan_if.sv
// carrier between the sequencer and one pointer/counter channel
`timescale 1ns/100ps
`default_nettype none
interface pdp_chan_if;
  logic wr_ptr;
  logic wr_cnt;
  logic wr_nptr;
  logic wr_ncnt;
  logic [31:0] wdata;
  logic done;
  logic [2:0] step;
  logic [31:0] ptr;
  logic [31:0] nptr;
  logic [15:0] cnt;
  logic [15:0] ncnt;
  logic end_flag;
  logic buff_flag;
  modport ctl (output wr_ptr, wr_cnt, wr_nptr, wr_ncnt, wdata, done, step,
               input ptr, nptr, cnt, ncnt, end_flag, buff_flag);
  modport chan (input wr_ptr, wr_cnt, wr_nptr, wr_ncnt, wdata, done, step,
                output ptr, nptr, cnt, ncnt, end_flag, buff_flag);
endinterface : pdp_chan_if
`default_nettype wire

// file: pdp_checker.sv
// concurrent checks on the dma channel pair ports
`timescale 1ns/100ps
`default_nettype none
module pdp_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pslverr,
  input wire logic rx_ready_trigger,
  input wire logic tx_ready_trigger,
  input wire logic [31:0] rx_holding_register,
  input wire logic rx_holding_read,
  input wire logic [31:0] tx_holding_data,
  input wire logic tx_holding_write,
  input wire logic bus_req,
  input wire logic bus_valid,
  input wire logic bus_write,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic [31:0] bus_rdata,
  input wire logic bus_done,
  input wire logic rx_buffer_end_flag,
  input wire logic tx_buffer_end_flag,
  input wire logic rx_all_buffers_full_flag
);
  logic unmapped;
  // anything outside the ten aligned words must be refused
  assign unmapped = paddr < 12'h100 || paddr > 12'h124 || paddr[1:0] != 2'h0;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // multi-step transfer shapes
  sequence rx_store;
    rx_holding_read ##1 (bus_valid && bus_write);
  endsequence
  sequence tx_store;
    (bus_valid && !bus_write && bus_done) ##1 tx_holding_write;
  endsequence
  a_rx_fetch_order: assert property (rx_holding_read |-> rx_store)
    else $error("memory write missing after holding read");
  a_rx_data_kept: assert property (
    rx_holding_read |=> bus_wdata == $past(rx_holding_register))
    else $error("receive data changed on its way");
  a_tx_after_read: assert property (bus_valid && !bus_write && bus_done |-> tx_store)
    else $error("holding write missing after memory read");
  a_tx_data_match: assert property (
    tx_holding_write |-> tx_holding_data == $past(bus_rdata))
    else $error("transmit data differs from memory");
  a_req_holds: assert property (bus_req && !bus_done |=> bus_req)
    else $error("bus request dropped early");
  a_addr_stable: assert property (
    bus_valid && !bus_done |=> bus_valid && $stable(bus_addr))
    else $error("bus address moved during access");
  a_req_has_cause: assert property (
    $rose(bus_req) |-> $past(rx_ready_trigger || tx_ready_trigger))
    else $error("bus request with no trigger");
  a_rx_end_cause: assert property (
    $rose(rx_buffer_end_flag) |-> $past(bus_done && bus_write))
    else $error("rx end flag without transfer");
  a_tx_end_cause: assert property ($rose(tx_buffer_end_flag) |-> $past(tx_holding_write))
    else $error("tx end flag without transfer");
  a_full_needs_end: assert property (rx_all_buffers_full_flag |-> rx_buffer_end_flag)
    else $error("full flag without end flag");
  a_map_error: assert property (psel && penable |-> pslverr == unmapped)
    else $error("error response wrong for address");
endmodule // pdp_checker
bind pdp_top pdp_checker chk (.pclk, .presetn, .psel, .penable, .paddr, .pslverr,
  .rx_ready_trigger, .tx_ready_trigger, .rx_holding_register, .rx_holding_read,
  .tx_holding_data, .tx_holding_write, .bus_req, .bus_valid, .bus_write, .bus_addr,
  .bus_wdata, .bus_rdata, .bus_done, .rx_buffer_end_flag, .tx_buffer_end_flag,
  .rx_all_buffers_full_flag);
`default_nettype wire

// file: pdp_mem_model.sv
// memory side model: grants the bus and answers accesses
`timescale 1ns/100ps
`default_nettype none
module pdp_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic bus_req,
  input wire logic bus_valid,
  input wire logic [31:0] bus_addr,
  input wire logic slow,
  output logic bus_gnt,
  output logic bus_done,
  output logic [31:0] bus_rdata
);
  logic [3:0] wait_q;
  logic done_d;
  // slow mode holds grant and completion back a few cycles
  assign done_d = bus_valid && !bus_done && (!slow || wait_q > 4'h5);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 4'h0;
      bus_gnt <= 1'b0;
      bus_done <= 1'b0;
      bus_rdata <= 32'h0;
    end else begin
      wait_q <= bus_req ? wait_q + 4'h1 : 4'h0;
      bus_gnt <= bus_req && !bus_done && (!slow || wait_q > 4'h2);
      bus_done <= done_d;
      // data only valid with done; churns otherwise so stale reads show
      bus_rdata <= done_d ? ~bus_addr : ~bus_rdata;
    end
  end
endmodule // pdp_mem_model
`default_nettype wire

// file: pdp_pkg.sv
// constants and types shared by the peripheral dma channel pair
package pdp_pkg;

  // register bus geometry
  localparam int PDP_ADDR_W = 12;
  localparam int PDP_DATA_W = 32;
  localparam int PDP_CNT_W = 16;

  // register byte offsets inside the owning peripheral
  localparam logic [11:0] PDP_OFF_RX_PTR = 12'h100;
  localparam logic [11:0] PDP_OFF_RX_CNT = 12'h104;
  localparam logic [11:0] PDP_OFF_TX_PTR = 12'h108;
  localparam logic [11:0] PDP_OFF_TX_CNT = 12'h10c;
  localparam logic [11:0] PDP_OFF_RX_NPTR = 12'h110;
  localparam logic [11:0] PDP_OFF_RX_NCNT = 12'h114;
  localparam logic [11:0] PDP_OFF_TX_NPTR = 12'h118;
  localparam logic [11:0] PDP_OFF_TX_NCNT = 12'h11c;
  localparam logic [11:0] PDP_OFF_CTRL = 12'h120;
  localparam logic [11:0] PDP_OFF_STATE = 12'h124;

  // control and state bit positions
  localparam int PDP_CTL_RX_EN = 0;
  localparam int PDP_CTL_RX_DIS = 1;
  localparam int PDP_CTL_TX_EN = 8;
  localparam int PDP_CTL_TX_DIS = 9;
  localparam int PDP_STS_RX_EN = 0;
  localparam int PDP_STS_TX_EN = 8;

  // reset values
  localparam logic [31:0] PDP_PTR_RST = 32'h0;
  localparam logic [15:0] PDP_CNT_RST = 16'h0;
  localparam logic PDP_EN_RST = 1'b0;

  // transfer size codes and channel indices
  localparam logic [1:0] PDP_SIZE_BYTE = 2'h0;
  localparam logic [1:0] PDP_SIZE_HALF = 2'h1;
  localparam logic [1:0] PDP_SIZE_WORD = 2'h2;
  localparam int PDP_CH_RX = 0;
  localparam int PDP_CH_TX = 1;

  // transfer sequencer states
  typedef enum logic [2:0] {
    PDP_IDLE,
    PDP_REQ,
    PDP_PRD,
    PDP_BUS,
    PDP_PWR
  } pdp_state_t;

endpackage : pdp_pkg

// file: pdp_top.sv
// peripheral dma channel pair: apb registers, request order, bus sequencer
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - each direction keeps a 16-bit count, minus one per finished transfer.
// - a count at zero means the buffer is done; no more transfers.
// - with next count zero at expiry, stop and raise the all-buffers flag.
// - a counter write mid-operation replaces the remaining count.
// - at expiry with next count nonzero, next pointer/count become current.
// - the next count reads zero after being taken over.
// - per direction an end-of-buffer and an end-of-both-buffers flag.
// - writing either counter of a direction clears its flags.
// - receive: win bus, read holding register, write to memory at pointer.
// - each transfer advances the pointer and decrements the count.
// - when the block is moved, signal the peripheral and stop.
// - transmit: win bus, read memory at pointer, write holding register.
// - simultaneous same-direction requests go by peripheral number.
// - requests raised at different times are served oldest first.
// - simultaneous receive and transmit requests: receive goes first.
// - ten registers sit at offsets 0x100 to 0x124, one word each.
// - pointers are full 32-bit, readable and writable any time.
// - receive next pointer becomes current pointer at chaining.
// - pointer steps by 1, 2 or 4 for byte, half or word.
// - all-buffers flag only when both current and next count are zero.
// - enable bit set enables unless disable is set too; zero does nothing.
// - state register shows each direction enabled or disabled.
module pdp_top
  import pdp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_ready_trigger,
  input wire logic tx_ready_trigger,
  input wire logic [1:0] xfer_size,
  input wire logic [31:0] rx_holding_register,
  output logic rx_holding_read,
  output logic [31:0] tx_holding_data,
  output logic tx_holding_write,
  output logic bus_req,
  input wire logic bus_gnt,
  output logic bus_valid,
  output logic bus_write,
  output logic [31:0] bus_addr,
  output logic [1:0] bus_size,
  output logic [31:0] bus_wdata,
  input wire logic [31:0] bus_rdata,
  input wire logic bus_done,
  output logic rx_buffer_end_flag,
  output logic tx_buffer_end_flag,
  output logic rx_all_buffers_full_flag,
  output logic tx_all_buffers_empty_flag
);

  // per-channel views, index 0 receive and 1 transmit
  logic [1:0] ch_wr_ptr;
  logic [1:0] ch_wr_cnt;
  logic [1:0] ch_wr_nptr;
  logic [1:0] ch_wr_ncnt;
  logic [1:0] ch_done;
  logic [31:0] ch_ptr [2];
  logic [31:0] ch_nptr [2];
  logic [15:0] ch_cnt [2];
  logic [15:0] ch_ncnt [2];
  logic [1:0] ch_end;
  logic [1:0] ch_buff;
  logic [2:0] step;

  // register bus
  logic wr_en;
  logic rd_setup;
  logic addr_hit;
  logic [31:0] rdata_d;
  logic [31:0] prdata_q;

  // request enables and ordering
  logic rx_en_q;
  logic tx_en_q;
  logic rx_req;
  logic tx_req;
  logic tx_first_q;
  logic pick_tx;

  // sequencer
  pdp_state_t state_q;
  logic dir_tx_q;
  logic [31:0] addr_q;
  logic [1:0] size_q;
  logic [31:0] data_q;

  // byte count of one transfer for the pointer step
  always_comb begin
    unique case (size_q)
      PDP_SIZE_BYTE: step = 3'h1;
      PDP_SIZE_HALF: step = 3'h2;
      default: step = 3'h4;
    endcase
  end

  // the two channels share one engine shape
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      pdp_chan_if cif ();
      assign cif.wr_ptr = ch_wr_ptr[g];
      assign cif.wr_cnt = ch_wr_cnt[g];
      assign cif.wr_nptr = ch_wr_nptr[g];
      assign cif.wr_ncnt = ch_wr_ncnt[g];
      assign cif.wdata = pwdata;
      assign cif.done = ch_done[g];
      assign cif.step = step;
      assign ch_ptr[g] = cif.ptr;
      assign ch_nptr[g] = cif.nptr;
      assign ch_cnt[g] = cif.cnt;
      assign ch_ncnt[g] = cif.ncnt;
      assign ch_end[g] = cif.end_flag;
      assign ch_buff[g] = cif.buff_flag;
      pdp_chan u_chan (
        .pclk(pclk),
        .presetn(presetn),
        .bus(cif.chan)
      );
    end
  endgenerate

  // zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;

  // address decode over the ten-word window
  always_comb begin
    unique case (paddr)
      PDP_OFF_RX_PTR, PDP_OFF_RX_CNT, PDP_OFF_TX_PTR, PDP_OFF_TX_CNT,
      PDP_OFF_RX_NPTR, PDP_OFF_RX_NCNT, PDP_OFF_TX_NPTR, PDP_OFF_TX_NCNT,
      PDP_OFF_CTRL, PDP_OFF_STATE: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  // unmapped word answers with an error, nothing stored
  assign pslverr = psel && penable && !addr_hit;

  // write strobes into the channels
  assign ch_wr_ptr[PDP_CH_RX] = wr_en && paddr == PDP_OFF_RX_PTR;
  assign ch_wr_ptr[PDP_CH_TX] = wr_en && paddr == PDP_OFF_TX_PTR;
  assign ch_wr_cnt[PDP_CH_RX] = wr_en && paddr == PDP_OFF_RX_CNT;
  assign ch_wr_cnt[PDP_CH_TX] = wr_en && paddr == PDP_OFF_TX_CNT;
  assign ch_wr_nptr[PDP_CH_RX] = wr_en && paddr == PDP_OFF_RX_NPTR;
  assign ch_wr_nptr[PDP_CH_TX] = wr_en && paddr == PDP_OFF_TX_NPTR;
  assign ch_wr_ncnt[PDP_CH_RX] = wr_en && paddr == PDP_OFF_RX_NCNT;
  assign ch_wr_ncnt[PDP_CH_TX] = wr_en && paddr == PDP_OFF_TX_NCNT;

  // read mux; control is write-only and reads zero
  always_comb begin
    rdata_d = 32'h0;
    unique case (paddr)
      PDP_OFF_RX_PTR: rdata_d = ch_ptr[PDP_CH_RX];
      PDP_OFF_RX_CNT: rdata_d = {16'h0, ch_cnt[PDP_CH_RX]};
      PDP_OFF_TX_PTR: rdata_d = ch_ptr[PDP_CH_TX];
      PDP_OFF_TX_CNT: rdata_d = {16'h0, ch_cnt[PDP_CH_TX]};
      PDP_OFF_RX_NPTR: rdata_d = ch_nptr[PDP_CH_RX];
      PDP_OFF_RX_NCNT: rdata_d = {16'h0, ch_ncnt[PDP_CH_RX]};
      PDP_OFF_TX_NPTR: rdata_d = ch_nptr[PDP_CH_TX];
      PDP_OFF_TX_NCNT: rdata_d = {16'h0, ch_ncnt[PDP_CH_TX]};
      PDP_OFF_STATE: begin
        rdata_d[PDP_STS_RX_EN] = rx_en_q;
        rdata_d[PDP_STS_TX_EN] = tx_en_q;
      end
      default: rdata_d = 32'h0;
    endcase
  end

  // read data captured in setup so it stands through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
    end else if (rd_setup) begin
      prdata_q <= rdata_d;
    end
  end
  assign prdata = prdata_q;

  // direction enables; disable wins when both bits are written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_en_q <= PDP_EN_RST;
      tx_en_q <= PDP_EN_RST;
    end else if (wr_en && paddr == PDP_OFF_CTRL) begin
      if (pwdata[PDP_CTL_RX_DIS]) begin
        rx_en_q <= 1'b0;
      end else if (pwdata[PDP_CTL_RX_EN]) begin
        rx_en_q <= 1'b1;
      end
      if (pwdata[PDP_CTL_TX_DIS]) begin
        tx_en_q <= 1'b0;
      end else if (pwdata[PDP_CTL_TX_EN]) begin
        tx_en_q <= 1'b1;
      end
    end
  end

  // a trigger counts only when enabled and a buffer is left
  assign rx_req = rx_ready_trigger && rx_en_q && ch_cnt[PDP_CH_RX] != 16'h0;
  assign tx_req = tx_ready_trigger && tx_en_q && ch_cnt[PDP_CH_TX] != 16'h0;

  // remember that transmit was raised before receive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_first_q <= 1'b0;
    end else if (tx_req && !rx_req) begin
      tx_first_q <= 1'b1;
    end else if (!tx_req) begin
      tx_first_q <= 1'b0;
    end
  end

  // one peripheral on this pair, so numbering order is trivially kept
  assign pick_tx = tx_req && (!rx_req || tx_first_q);

  // sequencer: one transfer at a time, started only from idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= PDP_IDLE;
    end else begin
      unique case (state_q)
        PDP_IDLE: begin
          if (rx_req || tx_req) begin
            state_q <= PDP_REQ;
          end
        end
        PDP_REQ: begin
          if (bus_gnt) begin
            state_q <= dir_tx_q ? PDP_BUS : PDP_PRD;
          end
        end
        PDP_PRD: begin
          state_q <= PDP_BUS;
        end
        PDP_BUS: begin
          if (bus_done) begin
            state_q <= dir_tx_q ? PDP_PWR : PDP_IDLE;
          end
        end
        PDP_PWR: begin
          state_q <= PDP_IDLE;
        end
        default: begin
          state_q <= PDP_IDLE;
        end
      endcase
    end
  end

  // direction chosen when the request leaves idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_tx_q <= 1'b0;
    end else if (state_q == PDP_IDLE && (rx_req || tx_req)) begin
      dir_tx_q <= pick_tx;
    end
  end

  // address and size frozen at grant; later pointer writes hit the next one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= 32'h0;
      size_q <= PDP_SIZE_BYTE;
    end else if (state_q == PDP_REQ && bus_gnt) begin
      addr_q <= dir_tx_q ? ch_ptr[PDP_CH_TX] : ch_ptr[PDP_CH_RX];
      size_q <= xfer_size;
    end
  end

  // data word: from holding register on receive, from memory on transmit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q <= 32'h0;
    end else if (state_q == PDP_PRD) begin
      data_q <= rx_holding_register;
    end else if (state_q == PDP_BUS && bus_done && dir_tx_q) begin
      data_q <= bus_rdata;
    end
  end

  // request held through the holding read too, so the grant is not lost midway
  always_comb begin
    unique case (state_q)
      PDP_REQ, PDP_PRD, PDP_BUS: bus_req = 1'b1;
      default: bus_req = 1'b0;
    endcase
  end

  // bus handshake outputs follow the state directly
  assign bus_valid = state_q == PDP_BUS;
  assign bus_write = bus_valid && !dir_tx_q;
  assign bus_addr = addr_q;
  assign bus_size = size_q;
  assign bus_wdata = data_q;

  // peripheral holding register strobes
  assign rx_holding_read = state_q == PDP_PRD;
  assign tx_holding_write = state_q == PDP_PWR;
  assign tx_holding_data = data_q;

  // completion pulses advance pointer and count of the served side
  assign ch_done[PDP_CH_RX] = state_q == PDP_BUS && bus_done && !dir_tx_q;
  assign ch_done[PDP_CH_TX] = state_q == PDP_PWR;

  // end flags toward the owning peripheral
  assign rx_buffer_end_flag = ch_end[PDP_CH_RX];
  assign tx_buffer_end_flag = ch_end[PDP_CH_TX];
  assign rx_all_buffers_full_flag = ch_buff[PDP_CH_RX];
  assign tx_all_buffers_empty_flag = ch_buff[PDP_CH_TX];

endmodule // pdp_top
`default_nettype wire

// file: pdp_top_tb.sv
// self-checking bench for the dma channel pair
`timescale 1ns/100ps
`default_nettype none
module pdp_top_tb;
  import pdp_pkg::*;
  `define CHK(g, e) chk(64'(g), 64'(e))
  `define WAIT(c) begin \
    int k; \
    k = 0; \
    do begin @(posedge pclk); k++; end while (!(c) && k < 60); \
    if (!(c)) bad_count++; \
  end
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
  logic rx_ready_trigger, tx_ready_trigger, rx_holding_read, tx_holding_write;
  logic bus_req, bus_gnt, bus_valid, bus_write, bus_done;
  logic rx_buffer_end_flag, tx_buffer_end_flag;
  logic rx_all_buffers_full_flag, tx_all_buffers_empty_flag;
  logic [11:0] paddr;
  logic [1:0] xfer_size, bus_size;
  logic [31:0] pwdata, prdata, rx_holding_register, tx_holding_data;
  logic [31:0] bus_addr, bus_wdata, bus_rdata, a;
  logic [32:0] rd_q[$];
  logic [31:0] tx_q[$];
  logic [63:0] mw_q[$];
  logic [31:0] ctl[5] = '{32'h301, 32'h100, 32'h0, 32'h3, 32'h200};
  logic [31:0] st[5] = '{32'h1, 32'h101, 32'h101, 32'h100, 32'h0};
  int bad_count, comparisons, seed;
  pdp_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rx_ready_trigger, .tx_ready_trigger, .xfer_size, .rx_holding_register,
    .rx_holding_read, .tx_holding_data, .tx_holding_write, .bus_req, .bus_gnt, .bus_valid,
    .bus_write, .bus_addr, .bus_size, .bus_wdata, .bus_rdata, .bus_done, .rx_buffer_end_flag,
    .tx_buffer_end_flag, .rx_all_buffers_full_flag, .tx_all_buffers_empty_flag);
  pdp_mem_model mem (.pclk, .presetn, .bus_req, .bus_valid, .bus_addr, .slow, .bus_gnt,
    .bus_done, .bus_rdata);
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic chk(logic [63:0] g, logic [63:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // apb master: request held until pready is seen at an edge
  task automatic apb(logic w, logic [11:0] ad, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    `WAIT(pready === 1'b1)
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so a following setup never rewrites psel in this step
    @(posedge pclk);
  endtask
  task automatic wr(logic [11:0] ad, logic [31:0] d);
    apb(1'b1, ad, d);
  endtask
  task automatic rd(logic [11:0] ad, logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, ad, 32'h0);
  endtask
  // one receive item; trigger held until the holding read
  task automatic do_rx(logic [31:0] ad);
    logic [31:0] d;
    d = $random(seed);
    mw_q.push_back({ad, d});
    slow <= d[5];
    rx_holding_register <= d;
    rx_ready_trigger <= 1'b1;
    `WAIT(rx_holding_read === 1'b1)
    rx_ready_trigger <= 1'b0;
    rx_holding_register <= ~d;
    `WAIT(bus_done === 1'b1 && bus_write === 1'b1)
    `CHK(bus_size, xfer_size);
    @(posedge pclk);
  endtask
  task automatic do_tx(logic [31:0] ad);
    tx_q.push_back(~ad);
    tx_ready_trigger <= 1'b1;
    `WAIT(tx_holding_write === 1'b1)
    tx_ready_trigger <= 1'b0;
    @(posedge pclk);
  endtask
  // a trigger that must not start anything
  task automatic idle_trig();
    rx_ready_trigger <= 1'b1;
    repeat (8) @(posedge pclk);
    `CHK(bus_req, 1'b0);
    rx_ready_trigger <= 1'b0;
  endtask
  // watcher: oldest expectation against each result
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) `CHK({pslverr, prdata}, rd_q.pop_front());
    if (tx_holding_write === 1'b1) `CHK(tx_holding_data, tx_q.pop_front());
    if (bus_valid && bus_write && bus_done) `CHK({bus_addr, bus_wdata}, mw_q.pop_front());
  end
  // hang guard, well past the sequence length
  initial begin
    #200000;
    bad_count++;
    print_verdict();
  end
  initial begin
    seed = 32'h0d9f;
    {psel, penable, pwrite, rx_ready_trigger, tx_ready_trigger, slow} = '0;
    paddr = 12'h0;
    pwdata = 32'h0;
    rx_holding_register = 32'h0;
    xfer_size = PDP_SIZE_WORD;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 11; i++) rd(12'h100 + 12'(4 * i), {i == 10, 32'h0});
    rd(12'h0fe, {1'b1, 32'h0});
    $display("test reset done");
    a = $random(seed);
    wr(PDP_OFF_TX_NPTR, a);
    rd(PDP_OFF_TX_NPTR, {1'b0, a});
    // a next count written while the current one is spent is taken over at once
    wr(PDP_OFF_RX_NCNT, 32'hffff_abcd);
    rd(PDP_OFF_RX_CNT, 33'h0abcd);
    rd(PDP_OFF_RX_NCNT, 33'h0);
    for (int i = 0; i < 5; i++) begin
      wr(PDP_OFF_CTRL, ctl[i]);
      rd(PDP_OFF_STATE, {1'b0, st[i]});
    end
    wr(PDP_OFF_STATE, 32'hffff_ffff);
    rd(PDP_OFF_STATE, 33'h0);
    $display("test registers done");
    xfer_size <= PDP_SIZE_HALF;
    wr(PDP_OFF_RX_PTR, 32'h1000);
    wr(PDP_OFF_RX_CNT, 32'h2);
    wr(PDP_OFF_RX_NPTR, 32'h2000);
    wr(PDP_OFF_RX_NCNT, 32'h1);
    idle_trig();
    rd(PDP_OFF_RX_CNT, 33'h2);
    wr(PDP_OFF_CTRL, 32'h1);
    do_rx(32'h1000);
    do_rx(32'h1002);
    rd(PDP_OFF_RX_PTR, 33'h2000);
    rd(PDP_OFF_RX_CNT, 33'h1);
    rd(PDP_OFF_RX_NCNT, 33'h0);
    `CHK({rx_buffer_end_flag, rx_all_buffers_full_flag}, 2'h2);
    do_rx(32'h2000);
    `CHK({rx_buffer_end_flag, rx_all_buffers_full_flag}, 2'h3);
    idle_trig();
    wr(PDP_OFF_RX_NCNT, 32'h0);
    @(posedge pclk);
    `CHK({rx_buffer_end_flag, rx_all_buffers_full_flag}, 2'h0);
    $display("test rx chain done");
    xfer_size <= PDP_SIZE_BYTE;
    wr(PDP_OFF_RX_CNT, 32'h3);
    do_rx(32'h2002);
    wr(PDP_OFF_RX_CNT, 32'h1);
    do_rx(32'h2003);
    rd(PDP_OFF_RX_CNT, 33'h0);
    `CHK(rx_all_buffers_full_flag, 1'b1);
    $display("test rewrite done");
    wr(PDP_OFF_CTRL, 32'h100);
    wr(PDP_OFF_TX_PTR, 32'h3000);
    wr(PDP_OFF_TX_CNT, 32'h4);
    a = 32'h3000;
    for (int s = 0; s < 4; s++) begin
      xfer_size <= 2'(s);
      slow <= s[0];
      do_tx(a);
      a = a + 32'(s > 1 ? 4 : s + 1);
    end
    rd(PDP_OFF_TX_PTR, {1'b0, a});
    `CHK({tx_buffer_end_flag, tx_all_buffers_empty_flag}, 2'h3);
    $display("test tx sizes done");
    wr(PDP_OFF_CTRL, 32'h101);
    wr(PDP_OFF_RX_CNT, 32'h1);
    wr(PDP_OFF_TX_CNT, 32'h1);
    fork
      do_rx(32'h2004);
      do_tx(32'h300b);
      begin
        `WAIT(bus_valid === 1'b1)
        `CHK(bus_write, 1'b1);
      end
    join
    $display("test order done");
    print_verdict();
  end
endmodule // pdp_top_tb
`default_nettype wire
